//--- ubc_pkg.sv
// Purpose: Shared constants and types of the break unit and its core agent
// Assumes: One clock, registers reached by index over the link
// Notes: Bit positions of selects and control follow the break registers
package ubc_pkg;

  // ************************************************************
  // Register indices
  // ************************************************************
  localparam logic [3:0] REG_ADDR_A = 4'h0;
  localparam logic [3:0] REG_AMASK_A = 4'h1;
  localparam logic [3:0] REG_BBR_A = 4'h2;
  localparam logic [3:0] REG_ADDR_B = 4'h3;
  localparam logic [3:0] REG_AMASK_B = 4'h4;
  localparam logic [3:0] REG_BBR_B = 4'h5;
  localparam logic [3:0] REG_DATA_B = 4'h6;
  localparam logic [3:0] REG_DMASK_B = 4'h7;
  localparam logic [3:0] REG_CTRL = 4'h8;
  localparam logic [3:0] REG_ASID_A = 4'h9;
  localparam logic [3:0] REG_ASID_B = 4'ha;
  localparam logic [3:0] REG_TRACE = 4'hb;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int BBR_SZ_LO = 0;
  localparam int BBR_RW_LO = 2;
  localparam int BBR_ID_LO = 4;
  localparam int BBR_CD_LO = 6;
  localparam int BBR_XYE = 8;
  localparam int BBR_XYS = 9;
  localparam int CTRL_ASM_A = 21;
  localparam int CTRL_ASM_B = 20;
  localparam int CTRL_MF_LO = 12;
  localparam int CTRL_PCTE = 11;
  localparam int CTRL_PCB_A = 10;
  localparam int CTRL_DBE_B = 7;
  localparam int CTRL_PCB_B = 6;
  localparam logic [31:0] CTRL_WMASK = 32'h0030_0cc0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] BBR_RST = 16'h0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam int TRACE_VALID = 31;
  localparam int TRACE_ADDR_W = 28;

  // ************************************************************
  // Encodings and types
  // ************************************************************
  localparam logic [1:0] SZ_NONE = 2'b00;
  localparam logic [1:0] SZ_BYTE = 2'b01;
  localparam logic [1:0] SZ_WORD = 2'b10;
  localparam logic [1:0] SZ_LONG = 2'b11;

  typedef enum logic [1:0] {
    BRK_PRE = 2'b00,
    BRK_POST = 2'b01,
    BRK_DATA = 2'b10,
    BRK_IO = 2'b11
  } brk_type_t;

  typedef struct packed {
    logic valid;
    logic dma;
    logic fetch;
    logic write;
    logic insn;
    logic io;
    logic xy;
    logic ysel;
    logic [1:0] size;
    logic [7:0] asid;
    logic [31:0] addr;
    logic [31:0] data;
  } bus_cyc_t;

  typedef struct packed {
    logic valid;
    logic accept;
    logic branch;
    logic [7:0] asid;
    logic [31:0] addr;
  } exec_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] amask;
    logic [15:0] bbr;
    logic [7:0] asid;
    logic asid_off;
    logic dbe;
    logic [31:0] data;
    logic [31:0] dmask;
  } ch_cfg_t;

endpackage

//--- ubc_link_if.sv
// Purpose: Link between break unit and core agent
// Assumes: Both ends on clk_sys
// Notes: Plain signals, no clocking
`timescale 1ns/100ps
`default_nettype none
interface ubc_link_if;
  import ubc_pkg::*;
  logic reg_wr;
  logic reg_rd;
  logic [3:0] reg_idx;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  bus_cyc_t cpu_cyc;
  bus_cyc_t dma_cyc;
  exec_t exec;
  logic brk_valid;
  brk_type_t brk_type;

  modport dev (
    input reg_wr, reg_rd, reg_idx, reg_wdata, cpu_cyc, dma_cyc, exec,
    output reg_rdata, reg_rvalid, brk_valid, brk_type
  );
  modport core (
    output reg_wr, reg_rd, reg_idx, reg_wdata, cpu_cyc, dma_cyc, exec,
    input reg_rdata, reg_rvalid, brk_valid, brk_type
  );
endinterface
`default_nettype wire

//--- break_matcher.sv
// Purpose: Compare one bus cycle against one channel condition
// Assumes: Purely combinational, cycle fields valid with cyc.valid
// Notes: HAS_DATA enables data value and X/Y bus compare
`timescale 1ns/100ps
`default_nettype none
module break_matcher
  import ubc_pkg::*;
#(
  parameter bit HAS_DATA = 1'b0
) (
  input wire ch_cfg_t cfg,
  input wire bus_cyc_t cyc,
  output logic hit
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] size_ignore(input logic [1:0] size);
    case (size)
      SZ_LONG: size_ignore = 32'h0000_0003;
      SZ_WORD: size_ignore = 32'h0000_0001;
      default: size_ignore = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [15:0] half(input logic [31:0] v, input logic ysel);
    half = ysel ? v[15:0] : v[31:16];
  endfunction

  // ************************************************************
  // Condition terms
  // ************************************************************
  logic [1:0] cd;
  logic [1:0] idf;
  logic [1:0] rw;
  logic [1:0] sz;
  logic xy_bus_break_enable;
  logic xy_bus_select;
  logic groups_ok;
  logic cyc_ok;
  logic asid_ok;
  logic addr_ok;
  logic data_ok;
  logic xy_ok;
  logic [31:0] ign;
  logic [31:0] dwin;

  assign cd = cfg.bbr[BBR_CD_LO +: 2];
  assign idf = cfg.bbr[BBR_ID_LO +: 2];
  assign rw = cfg.bbr[BBR_RW_LO +: 2];
  assign sz = cfg.bbr[BBR_SZ_LO +: 2];
  assign xy_bus_break_enable = HAS_DATA && cfg.bbr[BBR_XYE];
  assign xy_bus_select = cfg.bbr[BBR_XYS];
  assign groups_ok = (cd != 2'b00) && (idf != 2'b00) && (rw != 2'b00);
  assign cyc_ok = (cyc.dma ? cd[1] : cd[0]) && (cyc.fetch ? idf[0] : idf[1])
    && (cyc.write ? rw[1] : rw[0]) && (cyc.fetch || sz == SZ_NONE || sz == cyc.size);
  assign asid_ok = cfg.asid_off || (cfg.asid == cyc.asid);
  assign ign = cfg.amask | size_ignore(cyc.fetch ? SZ_WORD : cyc.size);
  assign addr_ok = ((cfg.addr ^ cyc.addr) & ~ign) == 32'h0000_0000;
  assign dwin = (cyc.size == SZ_LONG) ? 32'hffff_ffff : 32'h0000_ffff;
  assign data_ok = !HAS_DATA || !cfg.dbe || cyc.fetch
    || (((cfg.data ^ cyc.data) & ~cfg.dmask & dwin) == 32'h0000_0000);
  assign xy_ok = (cyc.ysel == xy_bus_select)
    && (((half(cfg.addr, xy_bus_select) ^ cyc.addr[15:0]) & ~half(cfg.amask, xy_bus_select)) == 16'h0000)
    && (!cfg.dbe || ((half(cfg.data, xy_bus_select) ^ cyc.data[15:0]) & ~half(cfg.dmask, xy_bus_select))
      == 16'h0000);
  assign hit = cyc.valid && groups_ok && cyc_ok && asid_ok && (cyc.xy == xy_bus_break_enable)
    && (xy_bus_break_enable ? xy_ok : (addr_ok && data_ok));

endmodule
`default_nettype wire

//--- break_unit_dev.sv
// Purpose: Two-channel user break unit with branch destination trace
// Assumes: Core reports executed instructions on exec, data cycles on cpu_cyc
// Notes: Registers reached by index over the link, read data one cycle later
// How it works
// - Trace holds first address after branch
// - Per-channel 8-bit space id, never reset
// - Zero cycle, id or read/write select blocks breaks; zero size select matches any size
// - Match raises request and reports break type
// - Match flags sticky, cleared by writing zero
// - Coinciding breaks give one request; a data or DMA hit beside any firing break, or an after hit beside a firing after or data break, requests again
// - Fetch select matches fetches, timing bit chooses
// - Before-break only on confirmed executed instruction
// - Delay-slot break taken at next accepting instruction
// - Software avoids delay-slot pre and sleep post
// - After-break raised before next instruction executes
// - Channel B data ignored on fetch
// - CPU data breaks only from instruction memory cycles
// - Address compare width follows access size
// - Data condition needs address and data match
// - Byte data replicated, upper half ignored
// - DMA data breaks use byte or word
// - X/Y bus break only on channel B
// - X/Y break uses CPU data word cycles
// - X uses upper halves, Y lower halves
// - Space id mask bit skips id check
`timescale 1ns/100ps
`default_nettype none
module break_unit_dev
  import ubc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  ubc_link_if.dev link,
  output logic break_request,
  output logic [3:0] match_flags
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [31:0] bar [2];
  logic [31:0] bamr [2];
  logic [15:0] bbr [2];
  logic [7:0] asid [2];
  logic [31:0] bdr;
  logic [31:0] bdmr;
  logic [31:0] ctrl;
  logic trace_valid;
  logic [TRACE_ADDR_W-1:0] trace_addr;
  logic pend_pre;
  logic pend_post;
  logic pend_data;
  logic pend_io;

  // ************************************************************
  // Decode and channel compare
  // ************************************************************
  logic wr_ctrl;
  logic rd_trace;
  logic [1:0] pcb;
  logic [1:0] fetch_hit;
  logic [1:0] data_hit;
  logic [1:0] dma_hit;
  logic io_hit;
  logic [3:0] flag_set;
  logic [3:0] flag_keep;
  ch_cfg_t cfg [2];
  bus_cyc_t exec_cyc;
  bus_cyc_t cpu_dat;
  bus_cyc_t dma_dat;

  assign wr_ctrl = link.reg_wr && (link.reg_idx == REG_CTRL);
  assign rd_trace = link.reg_rd && (link.reg_idx == REG_TRACE);
  assign pcb = {ctrl[CTRL_PCB_B], ctrl[CTRL_PCB_A]};

  always_comb begin
    exec_cyc = '0;
    exec_cyc.valid = link.exec.valid;
    exec_cyc.fetch = 1'b1;
    exec_cyc.insn = 1'b1;
    exec_cyc.size = SZ_WORD;
    exec_cyc.asid = link.exec.asid;
    exec_cyc.addr = link.exec.addr;
    cpu_dat = link.cpu_cyc;
    cpu_dat.dma = 1'b0;
    cpu_dat.valid = link.cpu_cyc.valid && link.cpu_cyc.insn && !link.cpu_cyc.fetch;
    dma_dat = link.dma_cyc;
    dma_dat.dma = 1'b1;
    dma_dat.fetch = 1'b0;
    dma_dat.xy = 1'b0;
  end

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    always_comb begin
      cfg[ch].addr = bar[ch];
      cfg[ch].amask = bamr[ch];
      cfg[ch].bbr = bbr[ch];
      cfg[ch].asid = asid[ch];
      cfg[ch].asid_off = (ch == 0) ? ctrl[CTRL_ASM_A] : ctrl[CTRL_ASM_B];
      cfg[ch].dbe = (ch == 1) && ctrl[CTRL_DBE_B];
      cfg[ch].data = bdr;
      cfg[ch].dmask = bdmr;
    end
    break_matcher #(.HAS_DATA(ch == 1)) u_fetch (
      .cfg(cfg[ch]),
      .cyc(exec_cyc),
      .hit(fetch_hit[ch])
    );
    break_matcher #(.HAS_DATA(ch == 1)) u_data (
      .cfg(cfg[ch]),
      .cyc(cpu_dat),
      .hit(data_hit[ch])
    );
    break_matcher #(.HAS_DATA(ch == 1)) u_dma (
      .cfg(cfg[ch]),
      .cyc(dma_dat),
      .hit(dma_hit[ch])
    );
  end

  assign io_hit = (|data_hit) && link.cpu_cyc.io;

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) begin
        bar[i] <= WORD_RST;
        bamr[i] <= WORD_RST;
        bbr[i] <= BBR_RST;
      end
      bdr <= WORD_RST;
      bdmr <= WORD_RST;
      ctrl <= CTRL_RST;
    end else if (link.reg_wr) begin
      case (link.reg_idx)
        REG_ADDR_A: bar[0] <= link.reg_wdata;
        REG_AMASK_A: bamr[0] <= link.reg_wdata;
        REG_BBR_A: bbr[0] <= {6'h00, 2'b00, link.reg_wdata[7:0]};
        REG_ADDR_B: bar[1] <= link.reg_wdata;
        REG_AMASK_B: bamr[1] <= link.reg_wdata;
        REG_BBR_B: bbr[1] <= {6'h00, link.reg_wdata[9:0]};
        REG_DATA_B: bdr <= link.reg_wdata;
        REG_DMASK_B: bdmr <= link.reg_wdata;
        REG_CTRL: ctrl <= link.reg_wdata & CTRL_WMASK;
        default: ;
      endcase
    end
  end

  // Space id registers keep their value through reset
  always_ff @(posedge clk_sys) begin
    if (link.reg_wr && link.reg_idx == REG_ASID_A) begin
      asid[0] <= link.reg_wdata[7:0];
    end
    if (link.reg_wr && link.reg_idx == REG_ASID_B) begin
      asid[1] <= link.reg_wdata[7:0];
    end
  end

  // ************************************************************
  // Sticky match flags
  // ************************************************************
  assign flag_set = {fetch_hit[0] | data_hit[0], fetch_hit[1] | data_hit[1],
    dma_hit[0], dma_hit[1]};
  assign flag_keep = wr_ctrl ? link.reg_wdata[CTRL_MF_LO +: 4] : 4'hf;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      match_flags <= FLAGS_RST;
    end else begin
      match_flags <= (match_flags & flag_keep) | flag_set;
    end
  end

  // ************************************************************
  // Branch destination trace
  // ************************************************************
  logic trace_set;
  assign trace_set = link.exec.valid && link.exec.branch && ctrl[CTRL_PCTE];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trace_valid <= 1'b0;
    end else begin
      trace_valid <= (trace_valid && !rd_trace) || trace_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (trace_set) begin
      trace_addr <= link.exec.addr[TRACE_ADDR_W-1:0];
    end
  end

  // ************************************************************
  // Register read
  // ************************************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = WORD_RST;
    case (link.reg_idx)
      REG_ADDR_A: rd_mux = bar[0];
      REG_AMASK_A: rd_mux = bamr[0];
      REG_BBR_A: rd_mux = {16'h0000, bbr[0]};
      REG_ADDR_B: rd_mux = bar[1];
      REG_AMASK_B: rd_mux = bamr[1];
      REG_BBR_B: rd_mux = {16'h0000, bbr[1]};
      REG_DATA_B: rd_mux = bdr;
      REG_DMASK_B: rd_mux = bdmr;
      REG_CTRL: begin
        rd_mux = ctrl;
        rd_mux[CTRL_MF_LO +: 4] = match_flags;
      end
      REG_ASID_A: rd_mux = {24'h00_0000, asid[0]};
      REG_ASID_B: rd_mux = {24'h00_0000, asid[1]};
      REG_TRACE: rd_mux = {trace_valid, 3'b000, trace_addr};
      default: rd_mux = WORD_RST;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link.reg_rdata <= WORD_RST;
      link.reg_rvalid <= 1'b0;
    end else begin
      link.reg_rvalid <= link.reg_rd;
      if (link.reg_rd) begin
        link.reg_rdata <= rd_mux;
      end
    end
  end

  // ************************************************************
  // Break request
  // ************************************************************
  logic pre_now;
  logic post_now;
  logic slot;
  logic fire;
  brk_type_t fire_type;

  assign pre_now = |(fetch_hit & ~pcb);
  assign post_now = |(fetch_hit & pcb);
  assign slot = link.exec.valid && link.exec.accept;

  always_comb begin
    fire = 1'b0;
    fire_type = BRK_DATA;
    if (slot) begin
      if (pre_now || pend_pre) begin
        fire = 1'b1;
        fire_type = BRK_PRE;
      end else if (pend_post) begin
        fire = 1'b1;
        fire_type = BRK_POST;
      end else if (pend_data) begin
        fire = 1'b1;
        fire_type = pend_io ? BRK_IO : BRK_DATA;
      end
    end
  end

  // One request per accepting slot; all pending causes merge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_pre <= 1'b0;
      pend_post <= 1'b0;
      pend_data <= 1'b0;
      pend_io <= 1'b0;
    end else begin
      pend_pre <= (pend_pre && !fire) || (pre_now && !slot);
      pend_post <= (pend_post && !fire) || (post_now && !(fire && fire_type == BRK_PRE));
      pend_data <= (pend_data && !fire) || (|data_hit) || (|dma_hit);
      pend_io <= (pend_io && !fire) || io_hit;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link.brk_valid <= 1'b0;
      link.brk_type <= BRK_PRE;
      break_request <= 1'b0;
    end else begin
      link.brk_valid <= fire;
      break_request <= fire;
      if (fire) begin
        link.brk_type <= fire_type;
      end
    end
  end

endmodule
`default_nettype wire

//--- break_core_agent.sv
// Purpose: Core-side end that programs the break unit and feeds bus cycles
// Assumes: User side is synchronous to clk_sys
// Notes: Illegal selects are refused and flagged on usr_reject
`timescale 1ns/100ps
`default_nettype none
module break_core_agent
  import ubc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  ubc_link_if.core link,
  input wire logic usr_wr,
  input wire logic usr_rd,
  input wire logic [3:0] usr_idx,
  input wire logic [31:0] usr_wdata,
  input wire bus_cyc_t usr_cpu_cyc,
  input wire bus_cyc_t usr_dma_cyc,
  input wire exec_t usr_exec,
  output logic [31:0] usr_rdata,
  output logic usr_rvalid,
  output logic usr_reject,
  output logic usr_brk_valid,
  output brk_type_t usr_brk_type
);

  // ************************************************************
  // Write checking
  // ************************************************************
  logic [1:0] sz_b;
  logic dbe;
  logic bad;
  logic is_bbr;
  logic [1:0] cd;
  logic [1:0] idf;
  logic [1:0] sz;
  logic [31:0] wdata;

  assign is_bbr = usr_idx == REG_BBR_A || usr_idx == REG_BBR_B;
  assign cd = usr_wdata[BBR_CD_LO +: 2];
  assign idf = usr_wdata[BBR_ID_LO +: 2];
  assign sz = usr_wdata[BBR_SZ_LO +: 2];

  always_comb begin
    bad = 1'b0;
    if (usr_wr && is_bbr && cd[1] && sz == SZ_LONG) begin
      bad = 1'b1;
    end
    if (usr_wr && usr_idx == REG_BBR_B && cd[1] && dbe && sz == SZ_NONE) begin
      bad = 1'b1;
    end
    if (usr_wr && usr_idx == REG_BBR_B && usr_wdata[BBR_XYE]
        && (cd != 2'b01 || idf != 2'b10 || sz == SZ_BYTE || sz == SZ_LONG)) begin
      bad = 1'b1;
    end
  end

  always_comb begin
    wdata = usr_wdata;
    if ((usr_idx == REG_DATA_B || usr_idx == REG_DMASK_B) && sz_b == SZ_BYTE) begin
      wdata[15:8] = usr_wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sz_b <= SZ_NONE;
      dbe <= 1'b0;
    end else if (usr_wr && !bad) begin
      if (usr_idx == REG_BBR_B) begin
        sz_b <= sz;
      end
      if (usr_idx == REG_CTRL) begin
        dbe <= usr_wdata[CTRL_DBE_B];
      end
    end
  end

  // ************************************************************
  // Link drive and answers
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      link.reg_idx <= REG_ADDR_A;
      link.reg_wdata <= WORD_RST;
      link.cpu_cyc <= '0;
      link.dma_cyc <= '0;
      link.exec <= '0;
      usr_reject <= 1'b0;
    end else begin
      link.reg_wr <= usr_wr && !bad;
      link.reg_rd <= usr_rd && !usr_wr;
      link.reg_idx <= usr_idx;
      link.reg_wdata <= wdata;
      link.cpu_cyc <= usr_cpu_cyc;
      link.dma_cyc <= usr_dma_cyc;
      link.exec <= usr_exec;
      usr_reject <= usr_wr && bad;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      usr_rdata <= WORD_RST;
      usr_rvalid <= 1'b0;
      usr_brk_valid <= 1'b0;
      usr_brk_type <= BRK_PRE;
    end else begin
      usr_rvalid <= link.reg_rvalid;
      if (link.reg_rvalid) begin
        usr_rdata <= link.reg_rdata;
      end
      usr_brk_valid <= link.brk_valid;
      usr_brk_type <= link.brk_type;
    end
  end

endmodule
`default_nettype wire

//--- break_unit_monitor.sv
// Purpose: Link checks for the break unit
// Assumes: One clock, reset low active
// Notes: Watches link and device outputs
`timescale 1ns/100ps
`default_nettype none
module break_unit_monitor
  import ubc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_idx,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire exec_t exec,
  input wire logic brk_valid,
  input wire brk_type_t brk_type,
  input wire logic break_request,
  input wire logic [3:0] match_flags
);
  // ****
  // Checks
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence rd_req;
    reg_rd && !reg_wr;
  endsequence
  a_read_answer: assert property (rd_req |=> reg_rvalid)
    else $error("read not answered");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  a_trace_reserved: assert property (
    rd_req ##0 reg_idx == REG_TRACE |=> reg_rdata[30:28] == 3'h0)
    else $error("trace reserved bits set");
  a_unmapped_zero: assert property (
    rd_req ##0 reg_idx > REG_TRACE |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_break_slot: assert property (
    brk_valid |-> $past(exec.valid && exec.accept))
    else $error("break outside accepting slot");
  a_break_request: assert property (brk_valid == break_request)
    else $error("request and type pulse differ");
  a_type_hold: assert property ($changed(brk_type) |-> brk_valid)
    else $error("break type changed alone");
  a_flags_sticky: assert property (
    |($past(match_flags) & ~match_flags) |-> $past(reg_wr && reg_idx == REG_CTRL))
    else $error("match flag cleared by hardware");
endmodule
`default_nettype wire

//--- tb_bus_cycle_break_unit.sv
// Purpose: Self-checking bench of break unit and core agent
// Assumes: Both ends joined by the link interface
// Notes: Random base address, space id and data, seed 16
`timescale 1ns/100ps
`default_nettype none
module tb_bus_cycle_break_unit;
  import ubc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic usr_wr = 1'b0;
  logic usr_rd = 1'b0;
  logic [3:0] usr_idx = 4'h0;
  logic [31:0] usr_wdata = 32'h0000_0000;
  bus_cyc_t usr_cpu_cyc = '0;
  bus_cyc_t usr_dma_cyc = '0;
  exec_t usr_exec = '0;
  logic [31:0] usr_rdata, rv, ba;
  logic usr_rvalid, usr_reject, usr_brk_valid, break_request, wrt = 1'b0, brn = 1'b0;
  brk_type_t usr_brk_type, brk_last;
  logic [3:0] match_flags;
  logic [7:0] s;
  logic [7:0] sel [4] = '{8'h14, 8'h44, 8'h50, 8'h54};
  logic [1:0] zt [6] = '{SZ_LONG, SZ_WORD, SZ_BYTE, SZ_BYTE, SZ_WORD, SZ_BYTE};
  logic [1:0] ot [6] = '{2'h0, 2'h2, 2'h3, 2'h2, 2'h0, 2'h3};
  logic [5:0] it = 6'h1f;
  int err_total = 0, checks = 0, brk_n = 0, cyc_n = 0, seed = 16, rj_n = 0, rv_n = 0;
  always #2 clk_sys = ~clk_sys;
  ubc_link_if ubc_link_if_inst ();
  break_unit_dev break_unit_dev_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(ubc_link_if_inst), .break_request(break_request), .match_flags(match_flags));
  break_core_agent break_core_agent_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(ubc_link_if_inst), .usr_wr(usr_wr), .usr_rd(usr_rd), .usr_idx(usr_idx),
    .usr_wdata(usr_wdata), .usr_cpu_cyc(usr_cpu_cyc), .usr_dma_cyc(usr_dma_cyc),
    .usr_exec(usr_exec), .usr_rdata(usr_rdata), .usr_rvalid(usr_rvalid),
    .usr_reject(usr_reject), .usr_brk_valid(usr_brk_valid), .usr_brk_type(usr_brk_type));
  break_unit_monitor break_unit_monitor_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_wr(ubc_link_if_inst.reg_wr), .reg_rd(ubc_link_if_inst.reg_rd),
    .reg_idx(ubc_link_if_inst.reg_idx), .reg_rdata(ubc_link_if_inst.reg_rdata),
    .reg_rvalid(ubc_link_if_inst.reg_rvalid), .exec(ubc_link_if_inst.exec),
    .brk_valid(ubc_link_if_inst.brk_valid), .brk_type(ubc_link_if_inst.brk_type),
    .break_request(break_request), .match_flags(match_flags));
  // ****
  // Tasks
  // ****
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic hit(input logic [1:0] z, input logic [31:0] a, input logic [31:0] b);
    logic [31:0] m;
    m = (z == SZ_LONG) ? 32'hffff_fffc : (z == SZ_WORD) ? 32'hffff_fffe : 32'hffff_ffff;
    return ((a ^ b) & m) == 32'h0000_0000;
  endfunction
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    @(posedge clk_sys);
    usr_wr <= 1'b1;
    usr_idx <= i;
    usr_wdata <= d;
    @(posedge clk_sys);
    usr_wr <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] i);
    int r0;
    r0 = rv_n;
    @(posedge clk_sys);
    usr_rd <= 1'b1;
    usr_idx <= i;
    @(posedge clk_sys);
    usr_rd <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 rv = usr_rdata;
    chk(32'(rv_n - r0), 32'h1);
  endtask
  task automatic ex(input logic [31:0] a, input logic [1:0] va, input logic [7:0] id, input int n);
    int b0;
    b0 = brk_n;
    @(posedge clk_sys);
    usr_exec <= '{va[1], va[0], brn, id, a};
    @(posedge clk_sys);
    usr_exec <= '0;
    repeat (5) @(posedge clk_sys);
    chk(32'(brk_n - b0), 32'(n));
  endtask
  task automatic cy(input logic [1:0] z, input logic [31:0] a, input logic ins,
    input logic [31:0] d, input int n);
    @(posedge clk_sys);
    usr_cpu_cyc <= '{1'b1, 1'b0, 1'b0, wrt, ins, 1'b0, 1'b0, 1'b0, z, 8'h00, a, d};
    @(posedge clk_sys);
    usr_cpu_cyc <= '0;
    ex(32'h0000_0002, 2'h3, 8'h00, n);
  endtask
  always @(posedge clk_sys) begin
    cyc_n++;
    rj_n += int'(usr_reject === 1'b1);
    rv_n += int'(usr_rvalid === 1'b1);
    if (usr_brk_valid === 1'b1) begin
      brk_n++;
      brk_last = usr_brk_type;
    end
    if (cyc_n == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  // ****
  // Tests
  // ****
  initial begin
    ba = $random(seed) & 32'h0fff_fff0;
    s = 8'($random(seed));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(REG_CTRL);
    chk(rv, CTRL_RST);
    wr(REG_CTRL, 32'h0030_0000);
    wr(REG_ADDR_A, ba);
    for (int k = 0; k < 4; k++) begin
      wr(REG_BBR_A, {24'h0, sel[k]});
      ex(ba, 2'h3, 8'h00, k == 3);
    end
    chk({30'h0, brk_last}, {30'h0, BRK_PRE});
    ex(ba, 2'h1, 8'h00, 0);
    ex(ba, 2'h2, 8'h00, 0);
    ex(ba + 8, 2'h3, 8'h00, 1);
    rd(REG_CTRL);
    chk(rv, 32'h0030_8000);
    wr(REG_CTRL, 32'h0030_0400);
    chk({28'h0, match_flags}, 32'h0);
    ex(ba, 2'h3, 8'h00, 0);
    ex(ba + 8, 2'h3, 8'h00, 1);
    chk({30'h0, brk_last}, {30'h0, BRK_POST});
    $display("fetch test done");
    wr(REG_CTRL, 32'h0010_0000);
    wr(REG_ASID_A, {24'h0, s});
    ex(ba, 2'h3, s ^ 8'h01, 0);
    ex(ba, 2'h3, s, 1);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(REG_ASID_A);
    chk(rv, {24'h0, s});
    $display("space id test done");
    wr(REG_CTRL, 32'h0030_0000);
    wr(REG_ADDR_A, ba | 32'h3);
    wr(REG_BBR_A, 32'h0000_0064);
    for (int k = 0; k < 6; k++) begin
      cy(zt[k], ba | {30'h0, ot[k]}, it[k], $random(seed),
        hit(zt[k], ba | {30'h0, ot[k]}, ba | 32'h3) && it[k]);
    end
    chk({30'h0, brk_last}, {30'h0, BRK_DATA});
    $display("data size test done");
    wr(REG_CTRL, 32'h0030_0080);
    wr(REG_BBR_A, 32'h0000_0000);
    wr(REG_BBR_B, 32'h0000_0069);
    wr(REG_ADDR_B, ba);
    wr(REG_DATA_B, 32'h0000_005a);
    rd(REG_DATA_B);
    chk(rv, 32'h0000_5a5a);
    wrt = 1'b1;
    cy(SZ_BYTE, ba, 1'b1, 32'h1234_5a5a, 1);
    cy(SZ_BYTE, ba, 1'b1, 32'h1234_5b5b, 0);
    cy(SZ_BYTE, ba + 1, 1'b1, 32'h0000_5a5a, 0);
    wrt = 1'b0;
    chk({28'h0, match_flags}, 32'h4);
    $display("data value test done");
    wr(REG_CTRL, 32'h0030_0800);
    brn = 1'b1;
    ex(ba, 2'h3, 8'h00, 0);
    brn = 1'b0;
    rd(REG_TRACE);
    chk(rv, {4'h8, ba[27:0]});
    rd(REG_TRACE);
    chk(rv, {4'h0, ba[27:0]});
    rd(4'hf);
    $display("trace test done");
    wr(REG_BBR_A, 32'h0000_00a7);
    chk(32'(rj_n), 32'h1);
    rd(REG_BBR_A);
    chk(rv, 32'h0000_0000);
    wr(REG_BBR_A, 32'h0000_00a5);
    @(posedge clk_sys);
    usr_dma_cyc <= {2'b11, 6'h00, SZ_BYTE, 8'h00, ba | 32'h3, 32'h0000_0000};
    @(posedge clk_sys);
    usr_dma_cyc <= '0;
    ex(32'h0000_0002, 2'h3, 8'h00, 1);
    chk({28'h0, match_flags}, 32'h2);
    chk({30'h0, brk_last}, {30'h0, BRK_DATA});
    $display("dma test done");
    end_of_test();
  end
endmodule
`default_nettype wire
